/* File: axis_fault_regs.svh */
// Constants for the axis fault detector
`ifndef AXIS_FAULT_REGS_SVH
`define AXIS_FAULT_REGS_SVH
`define CODE_NONE 16'h0000
`define CODE_MISSING_PROX 16'h0042
`define CODE_CW_SOFT 16'h0043
`define CODE_CCW_SOFT 16'h0044
`define CODE_HOME_UNDEF 16'h0045
`define CODE_SERVO_LOCK 16'h0046
`define CODE_PRESET_RANGE 16'h0047
`define CODE_ESTOP 16'h0048
`define FLAG_BIT 4'he
`define WORD_ZERO 16'h0000
`endif

/* File: axis_fault_pkg.sv */
// Types for the axis fault detector
package axis_fault_pkg;
  typedef enum logic [1:0] {
    STOP_NONE = 2'b00,
    STOP_DECEL = 2'b01,
    STOP_ACCUM = 2'b10,
    STOP_EMERG = 2'b11
  } stop_t;
  typedef enum logic [1:0] {
    SRCH_IDLE = 2'b00,
    SRCH_SEEK = 2'b01,
    SRCH_REV = 2'b10
  } search_t;
endpackage

/* File: soft_bound_check.sv */
// Software limit comparator for one target value
`timescale 1ns/1ps
module soft_bound_check (
  input wire logic check,
  input wire logic signed [31:0] value,
  input wire logic signed [31:0] cw_bound,
  input wire logic signed [31:0] ccw_bound,
  output logic cw_over,
  output logic ccw_over
);
  assign cw_over = check && (value > cw_bound);
  assign ccw_over = check && (value < ccw_bound);
endmodule

/* File: axis_fault_detector.sv */
// Axis fault detection, error code and stop method selection
// Functional notes
// [RQ1] One-way search: limit before proximity gives 0042, decel stop.
// [RQ2] Reverse search: no proximity between limits gives 0042, decel stop.
// [RQ3] Target beyond CW soft limit: 0043; decel before start, else accum.
// [RQ4] Same for CCW soft limit with code 0044.
// [RQ5] Move while origin undefined is refused, code 0045, decel stop.
// [RQ6] Motion or manual command without servo lock gives 0046, decel stop.
// [RQ7] Preset value out of range gives 0047, decel stop.
// [RQ8] Estop input or operation under estop gives 0048; stop by parameter.
// [RQ9] Two-axis variant: bit 14 of word n+10, code in word n+11.
// [RQ10] Four-axis variant: bit 14 of word n+18, code in word n+19.
// [RQ11] Flag and code hold until host error reset.
`timescale 1ns/1ps
`include "axis_fault_regs.svh"
module axis_fault_detector
  import axis_fault_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic four_axis_mode,
  input wire logic search_start,
  input wire logic search_reverse,
  input wire logic cw_limit,
  input wire logic ccw_limit,
  input wire logic proximity,
  input wire logic search_done,
  input wire logic move_cmd,
  input wire logic program_cmd,
  input wire logic manual_cmd,
  input wire logic motion_started,
  input wire logic home_defined,
  input wire logic servo_locked,
  input wire logic target_valid,
  input wire logic signed [31:0] target_value,
  input wire logic signed [31:0] cw_soft_bound,
  input wire logic signed [31:0] ccw_soft_bound,
  input wire logic preset_cmd,
  input wire logic signed [31:0] preset_value,
  input wire logic signed [31:0] preset_max,
  input wire logic signed [31:0] preset_min,
  input wire logic estop_input,
  input wire logic estop_uses_emergency,
  input wire logic error_reset,
  output logic move_refused,
  output logic missing_proximity_fault,
  output logic cw_soft_bound_fault,
  output logic ccw_soft_bound_fault,
  output logic home_undefined_fault,
  output logic preset_range_fault,
  output logic [1:0] stop_method,
  output logic [15:0] status_word_a,
  output logic [15:0] code_word_a,
  output logic [15:0] status_word_b,
  output logic [15:0] code_word_b
);
  search_t search_reg;
  logic first_limit_ccw_reg;
  logic prox_seen_reg;
  logic err_flag_reg;
  logic [15:0] err_code_reg;
  stop_t stop_reg;
  logic [15:0] code_next;
  stop_t stop_next;
  logic prox_fault;
  logic cw_over;
  logic ccw_over;
  logic preset_cw;
  logic preset_ccw;
  logic op_attempt;
  logic check_target;
  logic home_fault;
  logic lock_fault;
  logic preset_fault;
  logic estop_fault;

  // Soft limit stop depends on whether motion has begun
  function automatic stop_t bound_stop(input logic started);
    return started ? STOP_ACCUM : STOP_DECEL;
  endfunction

  assign op_attempt = move_cmd || program_cmd || manual_cmd;
  assign check_target = target_valid || preset_cmd;

  soft_bound_check u_target_check (
    .check(check_target),
    .value(preset_cmd ? preset_value : target_value),
    .cw_bound(cw_soft_bound),
    .ccw_bound(ccw_soft_bound),
    .cw_over(cw_over),
    .ccw_over(ccw_over)
  );

  soft_bound_check u_preset_check (
    .check(preset_cmd),
    .value(preset_value),
    .cw_bound(preset_max),
    .ccw_bound(preset_min),
    .cw_over(preset_cw),
    .ccw_over(preset_ccw)
  );

  // Origin search tracker; a missing-proximity fault or completion ends the search
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      search_reg <= SRCH_IDLE;
      prox_seen_reg <= 1'b0;
      first_limit_ccw_reg <= 1'b0;
    end else if (search_start) begin
      search_reg <= SRCH_SEEK;
      prox_seen_reg <= 1'b0;
    end else begin
      if (proximity) begin
        prox_seen_reg <= 1'b1;
      end
      unique case (search_reg)
        SRCH_IDLE: begin
        end
        SRCH_SEEK: begin
          if (search_done || prox_fault) begin
            search_reg <= SRCH_IDLE;
          end else if (search_reverse && !prox_seen_reg && !proximity &&
                       (cw_limit || ccw_limit)) begin
            // First limit reached; turn round and look for the other one
            search_reg <= SRCH_REV;
            first_limit_ccw_reg <= ccw_limit;
          end
        end
        SRCH_REV: begin
          if (search_done || prox_fault) begin
            search_reg <= SRCH_IDLE;
          end
        end
        default: search_reg <= SRCH_IDLE;
      endcase
    end
  end

  always_comb begin
    prox_fault = 1'b0;
    if (search_reg == SRCH_SEEK && !search_reverse &&
        !prox_seen_reg && !proximity && (cw_limit || ccw_limit)) begin
      prox_fault = 1'b1; // RQ1
    end
    if (search_reg == SRCH_REV && !prox_seen_reg && !proximity &&
        (first_limit_ccw_reg ? cw_limit : ccw_limit)) begin
      prox_fault = 1'b1; // RQ2
    end
  end

  assign home_fault = move_cmd && !home_defined; // RQ5
  assign lock_fault = (program_cmd || manual_cmd) && !servo_locked; // RQ6
  assign preset_fault = preset_cw || preset_ccw; // RQ7
  // Level input catches both the edge and retries after a reset
  assign estop_fault = estop_input; // RQ8
  assign move_refused = home_fault || (estop_input && op_attempt); // RQ5

  // Fixed priority: emergency stop outranks everything
  always_comb begin
    code_next = `CODE_NONE;
    stop_next = STOP_NONE;
    if (estop_fault) begin
      code_next = `CODE_ESTOP; // RQ8
      stop_next = estop_uses_emergency ? STOP_EMERG : STOP_ACCUM; // RQ8
    end else if (prox_fault) begin
      code_next = `CODE_MISSING_PROX; // RQ1
      stop_next = STOP_DECEL;
    end else if (cw_over) begin
      code_next = `CODE_CW_SOFT; // RQ3
      stop_next = bound_stop(motion_started); // RQ3
    end else if (ccw_over) begin
      code_next = `CODE_CCW_SOFT; // RQ4
      stop_next = bound_stop(motion_started); // RQ4
    end else if (home_fault) begin
      code_next = `CODE_HOME_UNDEF;
      stop_next = STOP_DECEL;
    end else if (lock_fault) begin
      code_next = `CODE_SERVO_LOCK;
      stop_next = STOP_DECEL;
    end else if (preset_fault) begin
      code_next = `CODE_PRESET_RANGE;
      stop_next = STOP_DECEL;
    end
  end

  // Latched error; a new fault in the reset cycle wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_flag_reg <= 1'b0;
      err_code_reg <= `CODE_NONE;
      stop_reg <= STOP_NONE;
    end else if (stop_next != STOP_NONE &&
                 (!err_flag_reg || error_reset)) begin
      err_flag_reg <= 1'b1; // RQ11
      err_code_reg <= code_next;
      stop_reg <= stop_next;
    end else if (error_reset) begin
      err_flag_reg <= 1'b0; // RQ11
      err_code_reg <= `CODE_NONE;
      stop_reg <= STOP_NONE;
    end
  end

  // Interface words, only the selected variant is driven
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_word_a <= `WORD_ZERO;
      code_word_a <= `WORD_ZERO;
      status_word_b <= `WORD_ZERO;
      code_word_b <= `WORD_ZERO;
    end else begin
      status_word_a <= `WORD_ZERO;
      code_word_a <= `WORD_ZERO;
      status_word_b <= `WORD_ZERO;
      code_word_b <= `WORD_ZERO;
      if (four_axis_mode) begin
        status_word_b[`FLAG_BIT] <= err_flag_reg; // RQ10
        code_word_b <= err_code_reg; // RQ10
      end else begin
        status_word_a[`FLAG_BIT] <= err_flag_reg; // RQ9
        code_word_a <= err_code_reg; // RQ9
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      missing_proximity_fault <= 1'b0;
      cw_soft_bound_fault <= 1'b0;
      ccw_soft_bound_fault <= 1'b0;
      home_undefined_fault <= 1'b0;
      preset_range_fault <= 1'b0;
      stop_method <= STOP_NONE;
    end else begin
      missing_proximity_fault <= err_code_reg == `CODE_MISSING_PROX;
      cw_soft_bound_fault <= err_code_reg == `CODE_CW_SOFT;
      ccw_soft_bound_fault <= err_code_reg == `CODE_CCW_SOFT;
      home_undefined_fault <= err_code_reg == `CODE_HOME_UNDEF;
      preset_range_fault <= err_code_reg == `CODE_PRESET_RANGE;
      stop_method <= stop_reg;
    end
  end

  a_estop_code: assert property (@(posedge core_clk) disable iff (!rstn) // RQ8
    estop_input && !err_flag_reg |=> err_code_reg == `CODE_ESTOP)
    else $error("estop code missing");
  a_prox_code: assert property (@(posedge core_clk) disable iff (!rstn) // RQ1
    prox_fault && !estop_input && !err_flag_reg
    |=> err_code_reg == `CODE_MISSING_PROX && stop_reg == STOP_DECEL)
    else $error("proximity fault not reported");
  a_rev_fault: assert property (@(posedge core_clk) disable iff (!rstn) // RQ2
    search_reg == SRCH_REV && !prox_seen_reg && !proximity && !search_start &&
    (first_limit_ccw_reg ? cw_limit : ccw_limit) |=> search_reg == SRCH_IDLE)
    else $error("reverse search not ended");
  a_cw_stop: assert property (@(posedge core_clk) disable iff (!rstn) // RQ3
    code_next == `CODE_CW_SOFT && !err_flag_reg
    |=> stop_reg == ($past(motion_started) ? STOP_ACCUM : STOP_DECEL))
    else $error("cw stop method wrong");
  a_ccw_code: assert property (@(posedge core_clk) disable iff (!rstn) // RQ4
    ccw_over && !cw_over && !estop_input && !prox_fault && !err_flag_reg
    |=> err_code_reg == `CODE_CCW_SOFT)
    else $error("ccw code missing");
  a_home_refuse: assert property (@(posedge core_clk) // RQ5
    disable iff (!rstn) move_cmd && !home_defined |-> move_refused)
    else $error("move not refused");
  a_lock_code: assert property (@(posedge core_clk) disable iff (!rstn) // RQ6
    code_next == `CODE_SERVO_LOCK && !err_flag_reg
    |=> err_code_reg == `CODE_SERVO_LOCK ##1 stop_method == STOP_DECEL)
    else $error("servo lock fault wrong");
  a_preset_code: assert property (@(posedge core_clk) // RQ7
    disable iff (!rstn) code_next == `CODE_PRESET_RANGE && !err_flag_reg
    |=> err_code_reg == `CODE_PRESET_RANGE)
    else $error("preset fault missing");
  a_word_a: assert property (@(posedge core_clk) disable iff (!rstn) // RQ9
    !four_axis_mode |=> code_word_a == $past(err_code_reg) &&
    status_word_a[`FLAG_BIT] == $past(err_flag_reg))
    else $error("word a wrong");
  a_word_b: assert property (@(posedge core_clk) disable iff (!rstn) // RQ10
    four_axis_mode |=> code_word_b == $past(err_code_reg) &&
    status_word_b[`FLAG_BIT] == $past(err_flag_reg))
    else $error("word b wrong");
  a_code_hold: assert property (@(posedge core_clk) disable iff (!rstn) // RQ11
    err_flag_reg && !error_reset |=> $stable(err_code_reg))
    else $error("code overwritten");
endmodule

/* File: axis_sensor_model.sv */
// Limit and proximity switch model for an origin search
`timescale 1ns/1ps
module axis_sensor_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic stop,
  input wire logic reverse,
  input wire logic prox_present,
  output logic cw_limit,
  output logic ccw_limit,
  output logic proximity
);
  logic [3:0] pos_reg;
  logic run_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= 1'b0;
      pos_reg <= 4'h0;
    end else if (start) begin
      run_reg <= 1'b1;
      pos_reg <= 4'h0;
    end else if (stop) begin
      run_reg <= 1'b0;
    end else if (run_reg && pos_reg != 4'hf) begin
      pos_reg <= pos_reg + 4'h1;
    end
  end
  // Switches pass by, so each is on only for a short stretch
  assign proximity = run_reg && prox_present && pos_reg == 4'h3;
  assign cw_limit = run_reg && pos_reg >= 4'h6 && pos_reg <= 4'h7;
  assign ccw_limit = run_reg && reverse && pos_reg >= 4'h9 &&
                     pos_reg <= 4'ha;
endmodule

/* File: testbench.sv */
// Self-checking bench for the axis fault detector
`timescale 1ns/1ps
`include "axis_fault_regs.svh"
module testbench
  import axis_fault_pkg::*;
();
  logic core_clk = 1'b0;
  logic rstn, four_axis_mode, search_start, search_reverse, search_done;
  logic cw_limit, ccw_limit, proximity, prox_present, move_cmd;
  logic program_cmd, manual_cmd, motion_started, home_defined;
  logic servo_locked, target_valid, preset_cmd, estop_input;
  logic estop_uses_emergency, error_reset, move_refused;
  logic missing_proximity_fault, cw_soft_bound_fault, ccw_soft_bound_fault;
  logic home_undefined_fault, preset_range_fault;
  logic [1:0] stop_method;
  logic [15:0] status_word_a, code_word_a, status_word_b, code_word_b;
  logic signed [31:0] target_value, cw_soft_bound, ccw_soft_bound;
  logic signed [31:0] preset_value, preset_max, preset_min;
  int bad_count = 0;
  int comparisons = 0;
  always #50 core_clk = ~core_clk;
  axis_fault_detector axis_fault_detector_inst (
    .core_clk(core_clk), .rstn(rstn), .four_axis_mode(four_axis_mode),
    .search_start(search_start), .search_reverse(search_reverse),
    .cw_limit(cw_limit), .ccw_limit(ccw_limit), .proximity(proximity),
    .search_done(search_done), .move_cmd(move_cmd),
    .program_cmd(program_cmd), .manual_cmd(manual_cmd),
    .motion_started(motion_started), .home_defined(home_defined),
    .servo_locked(servo_locked), .target_valid(target_valid),
    .target_value(target_value), .cw_soft_bound(cw_soft_bound),
    .ccw_soft_bound(ccw_soft_bound), .preset_cmd(preset_cmd),
    .preset_value(preset_value), .preset_max(preset_max),
    .preset_min(preset_min), .estop_input(estop_input),
    .estop_uses_emergency(estop_uses_emergency),
    .error_reset(error_reset), .move_refused(move_refused),
    .missing_proximity_fault(missing_proximity_fault),
    .cw_soft_bound_fault(cw_soft_bound_fault),
    .ccw_soft_bound_fault(ccw_soft_bound_fault),
    .home_undefined_fault(home_undefined_fault),
    .preset_range_fault(preset_range_fault),
    .stop_method(stop_method), .status_word_a(status_word_a),
    .code_word_a(code_word_a), .status_word_b(status_word_b),
    .code_word_b(code_word_b)
  );
  axis_sensor_model axis_sensor_model_inst (
    .core_clk(core_clk), .rstn(rstn), .start(search_start),
    .stop(search_done), .reverse(search_reverse),
    .prox_present(prox_present), .cw_limit(cw_limit),
    .ccw_limit(ccw_limit), .proximity(proximity)
  );
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Words are due two edges after the cause; the third gives margin
  task automatic expect_err(input logic [15:0] code, input stop_t how);
    step(3);
    check("code", code, four_axis_mode ? code_word_b : code_word_a);
    check("flag", 16'h4000,
          (four_axis_mode ? status_word_b : status_word_a) & 16'h4000);
    check("stop", {14'h0, how}, {14'h0, stop_method});
  endtask
  task automatic clear_err();
    pulse(error_reset);
    step(3);
    check("cleared", `CODE_NONE, code_word_a | code_word_b);
    check("flag cleared", 16'h0, status_word_a | status_word_b);
  endtask
  task automatic t_search();
    pulse(search_start);
    step(8);
    expect_err(`CODE_MISSING_PROX, STOP_DECEL);
    check("prox", 16'h1, {15'h0, missing_proximity_fault});
    clear_err();
    prox_present = 1'b1;
    pulse(search_start);
    // Run past the limit so a seen proximity must suppress the fault
    step(8);
    pulse(search_done);
    step(6);
    check("found", `CODE_NONE, code_word_a);
    prox_present = 1'b0;
    search_reverse = 1'b1;
    pulse(search_start);
    step(9);
    check("first limit", `CODE_NONE, code_word_a);
    step(2);
    expect_err(`CODE_MISSING_PROX, STOP_DECEL);
    search_reverse = 1'b0;
    clear_err();
    $display("test search done");
  endtask
  task automatic t_bounds();
    target_value = 32'sh7d0;
    pulse(target_valid);
    expect_err(`CODE_CW_SOFT, STOP_DECEL);
    check("cw", 16'h1, {15'h0, cw_soft_bound_fault});
    clear_err();
    motion_started = 1'b1;
    target_value = -32'sh7d0;
    pulse(target_valid);
    expect_err(`CODE_CCW_SOFT, STOP_ACCUM);
    check("ccw", 16'h1, {15'h0, ccw_soft_bound_fault});
    clear_err();
    target_value = 32'sh3e8;
    pulse(target_valid);
    step(3);
    check("at bound", `CODE_NONE, code_word_a);
    target_value = 32'sh7d0;
    pulse(target_valid);
    expect_err(`CODE_CW_SOFT, STOP_ACCUM);
    clear_err();
    motion_started = 1'b0;
    $display("test bounds done");
  endtask
  task automatic t_commands();
    home_defined = 1'b0;
    move_cmd = 1'b1;
    #1 check("refused", 16'h1, {15'h0, move_refused});
    step(1);
    move_cmd = 1'b0;
    expect_err(`CODE_HOME_UNDEF, STOP_DECEL);
    check("home", 16'h1, {15'h0, home_undefined_fault});
    home_defined = 1'b1;
    clear_err();
    servo_locked = 1'b0;
    pulse(manual_cmd);
    expect_err(`CODE_SERVO_LOCK, STOP_DECEL);
    preset_value = 32'sh2bc;
    pulse(preset_cmd);
    expect_err(`CODE_SERVO_LOCK, STOP_DECEL);
    clear_err();
    pulse(program_cmd);
    expect_err(`CODE_SERVO_LOCK, STOP_DECEL);
    servo_locked = 1'b1;
    clear_err();
    $display("test commands done");
  endtask
  task automatic t_preset();
    four_axis_mode = 1'b1;
    preset_value = 32'sh2bc;
    pulse(preset_cmd);
    expect_err(`CODE_PRESET_RANGE, STOP_DECEL);
    check("word a", `WORD_ZERO, code_word_a);
    check("range", 16'h1, {15'h0, preset_range_fault});
    clear_err();
    preset_value = 32'sh1f4;
    pulse(preset_cmd);
    step(3);
    check("in range", `CODE_NONE, code_word_b);
    // Soft limit outranks the preset range check
    preset_value = 32'sh7d0;
    pulse(preset_cmd);
    expect_err(`CODE_CW_SOFT, STOP_DECEL);
    clear_err();
    four_axis_mode = 1'b0;
    $display("test preset done");
  endtask
  task automatic t_estop();
    stop_t how;
    for (int i = 0; i < 2; i++) begin
      how = i ? STOP_EMERG : STOP_ACCUM;
      estop_uses_emergency = i[0];
      estop_input = 1'b1;
      move_cmd = 1'b1;
      #1 check("estop refused", 16'h1, {15'h0, move_refused});
      step(1);
      move_cmd = 1'b0;
      expect_err(`CODE_ESTOP, how);
      // Reset while the input is still on must not clear it
      pulse(error_reset);
      step(1);
      check("held", 16'h4000, status_word_a & 16'h4000);
      expect_err(`CODE_ESTOP, how);
      estop_input = 1'b0;
      clear_err();
    end
    $display("test estop done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {rstn, four_axis_mode, search_start, search_reverse, search_done} = '0;
    {prox_present, move_cmd, program_cmd, manual_cmd, motion_started} = '0;
    {target_valid, preset_cmd, estop_input, error_reset} = '0;
    {estop_uses_emergency, home_defined, servo_locked} = 3'h3;
    {target_value, preset_value} = '0;
    cw_soft_bound = 32'sh3e8;
    ccw_soft_bound = -32'sh3e8;
    preset_max = 32'sh1f4;
    preset_min = -32'sh1f4;
    step(3);
    rstn = 1'b1;
    step(1);
    t_search();
    t_bounds();
    t_commands();
    t_preset();
    t_estop();
    results();
  end
  initial begin
    #(100 * 2000);
    bad_count++;
    results();
  end
endmodule
